// [bench/serial_flash_status_and_read_commands_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("Error %s expected %h seen %h", what, exp, got); \
    end \
  end
module serial_flash_status_and_read_commands_bench;
  import sfs_pkg::*;
  logic        clk_sys;
  logic        rst_n;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  io_i;
  logic [3:0]  io_o;
  logic [3:0]  io_oe;
  logic [23:0] mem_addr;
  logic [7:0]  mem_rdata;
  logic        mem_wr;
  logic [7:0]  mem_wdata;
  logic        busy;
  logic        write_enable_latch;
  logic        quad_lane_enable;
  logic [15:0] rd;
  logic [3:0]  oe_or;
  int          err_count;
  int          check_count;
  logic [7:0]  wr_count = 8'h00;
  logic [7:0]  wr_data;
  logic [23:0] wr_addr;

  // long enough that a status poll fits inside the write cycle
  sfs_core #(.STATUS_WRITE_CLKS(1000)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_i(io_i),
    .io_o(io_o), .io_oe(io_oe), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .busy(busy),
    .write_enable_latch(write_enable_latch), .quad_lane_enable(quad_lane_enable)
  );

  sfs_host_model host (
    .clk_sys(clk_sys), .io_o(io_o), .io_oe(io_oe), .sclk(sclk), .cs_n(cs_n), .io_i(io_i)
  );

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // array content is a fixed pattern of the address
  always @(negedge clk_sys) mem_rdata <= mem_addr[7:0] ^ 8'h5a;

  // record every array write the device issues
  always @(posedge clk_sys)
    if (mem_wr)
    begin
      wr_count <= wr_count + 8'h01;
      wr_data  <= mem_wdata;
      wr_addr  <= mem_addr;
    end

  task automatic give_verdict();
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic send(input logic [7:0] c, input int nin, input logic [23:0] d, input int nout);
    host.frame(c, 1, nin, {8'h00, d}, nout, rd, oe_or);
  endtask

  task automatic xfer(input logic [7:0] c, input int lw, input int nin, input logic [31:0] d, input int nout);
    host.frame(c, lw, nin, d, nout, rd, oe_or);
  endtask

  task automatic vol_write(input logic [7:0] c, input int nin, input logic [23:0] d);
    send(CMD_VOL_ENABLE, 0, 24'h000000, 0);
    send(c, nin, d, 0);
  endtask

  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    give_verdict();
  end

  initial
  begin
    err_count   = 0;
    check_count = 0;
    rst_n       = 1'b0;
    repeat (10) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    `CHK("wel reset", 1'b0, write_enable_latch)
    `CHK("busy reset", 1'b0, busy)
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 reset", 16'h0000, rd)
    send(CMD_WR_ENABLE, 0, 24'h000000, 0);
    `CHK("wel set", 1'b1, write_enable_latch)
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 repeat", 16'h0202, rd)
    `CHK("sr1 lane", 4'b0010, oe_or)
    send(CMD_WR_DISABLE, 0, 24'h000000, 0);
    `CHK("wel clear", 1'b0, write_enable_latch)
    send(CMD_VOL_ENABLE, 0, 24'h000000, 0);
    `CHK("wel after arm", 1'b0, write_enable_latch)
    send(CMD_WR_STATUS1, 8, 24'h0000ff, 0);
    `CHK("busy volatile", 1'b0, busy)
    `CHK("wel volatile", 1'b0, write_enable_latch)
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 mask", 16'h7c7c, rd)
    vol_write(CMD_WR_STATUS2, 8, 24'h0000ff);
    send(CMD_RD_STATUS2, 0, 24'h000000, 16);
    `CHK("sr2 mask", 16'h7b7b, rd)
    `CHK("qe set", 1'b1, quad_lane_enable)
    vol_write(CMD_WR_STATUS2, 8, 24'h000000);
    send(CMD_RD_STATUS2, 0, 24'h000000, 16);
    `CHK("sr2 locks", 16'h3939, rd)
    `CHK("qe clear", 1'b0, quad_lane_enable)
    vol_write(CMD_WR_STATUS3, 8, 24'h0000ff);
    send(CMD_RD_STATUS3, 0, 24'h000000, 16);
    `CHK("sr3 mask", 16'h6464, rd)
    vol_write(CMD_WR_STATUS1, 16, 24'h001c40);
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 pair", 16'h1c1c, rd)
    send(CMD_RD_STATUS2, 0, 24'h000000, 16);
    `CHK("sr2 pair", 16'h7979, rd)
    send(CMD_WR_STATUS1, 8, 24'h000000, 0);
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 no latch", 16'h1c1c, rd)
    send(CMD_WR_ENABLE, 0, 24'h000000, 0);
    send(CMD_WR_STATUS1, 8, 24'h000000, 0);
    `CHK("busy nv", 1'b1, busy)
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("busy polled", 1'b1, rd[8])
    send(CMD_READ, 24, 24'h000010, 8);
    `CHK("read while busy", 4'b0000, oe_or)
    for (int i = 0; i < 2000 && busy !== 1'b0; i++)
      @(negedge clk_sys);
    `CHK("busy end", 1'b0, busy)
    `CHK("wel after nv", 1'b0, write_enable_latch)
    send(CMD_RD_STATUS1, 0, 24'h000000, 16);
    `CHK("sr1 nv", 16'h0000, rd)
    send(CMD_READ, 24, 24'h0000fe, 16);
    `CHK("read data", 16'ha4a5, rd)
    `CHK("read lane", 4'b0010, oe_or)
    send(8'hc3, 0, 24'h000000, 8);
    `CHK("unknown quiet", 4'b0000, oe_or)
    send(CMD_QUAD_IO_RD, 0, 24'h000000, 8);
    `CHK("quad refused", 4'b0000, oe_or)
    xfer(CMD_DUAL_IO_RD, 2, 16, 32'h000020f0, 8);
    `CHK("dual data", 16'h7a7b, rd)
    `CHK("dual lanes", 4'b0011, oe_or)
    send(CMD_WR_ENABLE, 0, 24'h000000, 0);
    xfer(CMD_PROGRAM, 1, 32, 32'h0001ffa5, 0);
    `CHK("prog count", 8'h01, wr_count)
    `CHK("prog addr", 24'h0001ff, wr_addr)
    `CHK("prog data", 8'ha5, wr_data)
    `CHK("prog wrap", 24'h000100, mem_addr)
    `CHK("wel after prog", 1'b0, write_enable_latch)
    vol_write(CMD_WR_STATUS2, 8, 24'h000002);
    `CHK("qe on", 1'b1, quad_lane_enable)
    xfer(CMD_SET_WRAP, 4, 8, 32'hffffff2f, 0);
    xfer(CMD_QUAD_IO_RD, 4, 12, 32'h00000ff0, 4);
    `CHK("quad wrap", 16'h555a, rd)
    `CHK("quad lanes", 4'hf, oe_or)
    send(CMD_RESET_EN, 0, 24'h000000, 0);
    send(CMD_RESET, 0, 24'h000000, 0);
    send(CMD_RD_STATUS2, 0, 24'h000000, 16);
    `CHK("sr2 restored", 16'h3939, rd)
    `CHK("qe after reset", 1'b0, quad_lane_enable)
    `CHK("wel after reset", 1'b0, write_enable_latch)
    give_verdict();
  end
endmodule // serial_flash_status_and_read_commands_bench
`undef CHK
`default_nettype wire

// [bench/sfs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sfs_host_model (
  input  wire logic       clk_sys,
  input  wire logic [3:0] io_o,
  input  wire logic [3:0] io_oe,
  output var  logic       sclk,
  output var  logic       cs_n,
  output var  logic [3:0] io_i
);
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_i = 4'h0;
  end

  // half of a 200 ns link period, moved only at falling clk_sys edges
  task automatic half();
    repeat (4) @(negedge clk_sys);
  endtask

  // command on one lane, then nin clocks of lw lanes out, then nout clocks of lw lanes back
  task automatic frame(input logic [7:0] cmd, input int lw, input int nin, input logic [31:0] din,
                       input int nout, output logic [15:0] dout, output logic [3:0] oe_or);
    logic [39:0] sh;
    int          w;
    sh    = {cmd, din << ((nin * lw >= 32) ? 0 : 32 - nin * lw)};
    dout  = 16'h0000;
    oe_or = 4'h0;
    cs_n  = 1'b0;
    half();
    for (int i = 0; i < 8 + nin; i++)
    begin
      w    = (i < 8) ? 1 : lw;
      io_i = (w == 1) ? {io_i[3:1], sh[39]} : ((w == 2) ? {io_i[3:2], sh[39:38]} : sh[39:36]);
      sh   = sh << w;
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    // the host line is not a real value while the device talks
    io_i = ~io_i;
    for (int i = 0; i < nout; i++)
    begin
      half();
      dout  = (lw == 1) ? {dout[14:0], io_o[1]} : ((lw == 2) ? {dout[13:0], io_o[1:0]} : {dout[11:0], io_o});
      oe_or = oe_or | io_oe;
      sclk  = 1'b1;
      half();
      sclk  = 1'b0;
    end
    half();
    cs_n = 1'b1;
    io_i = ~io_i;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule // sfs_host_model
`default_nettype wire

// [common/sfs_pkg.sv]
`default_nettype none
package sfs_pkg;
  localparam logic [7:0] CMD_WR_ENABLE   = 8'h06;
  localparam logic [7:0] CMD_VOL_ENABLE  = 8'h50;
  localparam logic [7:0] CMD_WR_DISABLE  = 8'h04;
  localparam logic [7:0] CMD_RD_STATUS1  = 8'h05;
  localparam logic [7:0] CMD_RD_STATUS2  = 8'h35;
  localparam logic [7:0] CMD_RD_STATUS3  = 8'h15;
  localparam logic [7:0] CMD_WR_STATUS1  = 8'h01;
  localparam logic [7:0] CMD_WR_STATUS2  = 8'h31;
  localparam logic [7:0] CMD_WR_STATUS3  = 8'h11;
  localparam logic [7:0] CMD_READ        = 8'h03;
  localparam logic [7:0] CMD_PROGRAM     = 8'h02;
  localparam logic [7:0] CMD_DUAL_IO_RD  = 8'hbb;
  localparam logic [7:0] CMD_QUAD_IO_RD  = 8'heb;
  localparam logic [7:0] CMD_SET_WRAP    = 8'h77;
  localparam logic [7:0] CMD_RESET_EN    = 8'h66;
  localparam logic [7:0] CMD_RESET       = 8'h99;
  // status bit positions and write masks
  localparam int         SR1_BUSY_BIT    = 0;
  localparam int         SR1_WEL_BIT     = 1;
  localparam int         SR2_QE_BIT      = 1;
  localparam logic [7:0] SR1_WR_MASK     = 8'h7c;
  localparam logic [7:0] SR2_WR_MASK     = 8'h7b;
  localparam logic [7:0] SR3_WR_MASK     = 8'h64;
  localparam logic [7:0] SR2_OTP_MASK    = 8'h39;
  localparam logic [7:0] NO_OTP_MASK     = 8'h00;
  localparam logic [7:0] SR_RESET_VAL    = 8'h00;
  localparam logic [1:0] WRAP_LEN_RESET  = 2'h0;
  localparam int         WRAP_MIN_BYTES  = 8;
  localparam int         ADDR_BITS       = 24;
  localparam int         MODE_BITS       = 8;
  localparam int         QUAD_DUMMY_CLKS = 4;
  localparam int         WRAP_NIBBLE_POS = 6;
  localparam int         WRAP_CLKS       = 8;
  // timing
  localparam int         CLK_MHZ                 = 40;
  localparam int         STATUS_WRITE_TIME_US    = 10000;
  localparam int         STATUS_WRITE_CYCLES     = STATUS_WRITE_TIME_US * CLK_MHZ;
  localparam int         VOLATILE_REFRESH_TIME_NS = 50;
  localparam int         VOLATILE_REFRESH_CYCLES  = (VOLATILE_REFRESH_TIME_NS * CLK_MHZ) / 1000;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CMD   = 3'b001,
    ST_ADDR  = 3'b011,
    ST_MODE  = 3'b010,
    ST_DUMMY = 3'b110,
    ST_DOUT  = 3'b111,
    ST_DIN   = 3'b101,
    ST_QUIET = 3'b100
  } sfs_state_type;
endpackage
`default_nettype wire

// [hdl/sfs_core.sv]
`timescale 1ns/1ps
`default_nettype none
module sfs_core
  import sfs_pkg::*;
#(
  parameter int STATUS_WRITE_CLKS = sfs_pkg::STATUS_WRITE_CYCLES
) (
  input  wire  logic        clk_sys,
  input  wire  logic        rst_n,
  input  wire  logic        sclk,
  input  wire  logic        cs_n,
  input  wire  logic [3:0]  io_i,
  output var   logic [3:0]  io_o,
  output var   logic [3:0]  io_oe,
  output var   logic [23:0] mem_addr,
  input  wire  logic [7:0]  mem_rdata,
  output var   logic        mem_wr,
  output var   logic [7:0]  mem_wdata,
  output var   logic        busy,
  output var   logic        write_enable_latch,
  output var   logic        quad_lane_enable
);
  import sfs_pkg::*;

  logic [2:0]    sclk_s_q, cs_s_q;
  logic [3:0]    io_s1_q, io_s2_q;
  logic          sclk_rise, sclk_fall, cs_rise;
  sfs_state_type state_q;
  logic [7:0]    cmd_q, out_sh_q, b0_q, b1_q;
  logic [23:0]   sh_q;
  logic [4:0]    cnt_q;
  logic [3:0]    bits_left_q;
  logic [2:0]    lw_q;
  logic [1:0]    din_n_q, sel_q;
  logic [23:0]   addr_q;
  logic          mem_wr_q;
  logic [7:0]    wdata_q;
  logic [3:0]    io_o_q, io_oe_q;
  logic [7:0]    cur_sr_q [3];
  logic [7:0]    nv_sr_q  [3];
  logic          wel_q, busy_q, vol_arm_q, rst_arm_q, wrap_disable_q;
  logic [1:0]    wrap_length_q;
  logic [31:0]   busy_cnt_q;

  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] io, input logic [2:0] lw);
    case (lw)
      3'd1:    shift_in = {sh[22:0], io[0]};
      3'd2:    shift_in = {sh[21:0], io[1:0]};
      default: shift_in = {sh[19:0], io[3:0]};
    endcase
  endfunction

  function automatic logic [4:0] phase_clks(input logic [4:0] bits, input logic [2:0] lw);
    phase_clks = (lw == 3'd4) ? (bits >> 2) : ((lw == 3'd2) ? (bits >> 1) : bits);
  endfunction

  function automatic logic [7:0] sr_merge(input logic [7:0] old, input logic [7:0] data,
                                          input logic [7:0] wmask, input logic [7:0] otp);
    sr_merge = (old & ~wmask) | (data & wmask) | (old & otp);
  endfunction

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap_on, input logic [1:0] wlen);
    logic [23:0] span;
    span = 24'(WRAP_MIN_BYTES) << wlen;
    if (wrap_on)
      next_addr = (a & ~(span - 24'h1)) | ((a + 24'h1) & (span - 24'h1));
    else
      next_addr = a + 24'h1;
  endfunction

  // synchronisers: only stage two and later are read
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      io_s1_q  <= 4'h0;
      io_s2_q  <= 4'h0;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      cs_s_q   <= {cs_s_q[1:0], cs_n};
      io_s1_q  <= io_i;
      io_s2_q  <= io_s1_q;
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign cs_rise   = cs_s_q[1] & ~cs_s_q[2];

  logic [7:0] in_byte, rd_byte, sr_view;
  logic       cmd_done;
  logic       is_read;
  assign in_byte  = {sh_q[6:0], io_s2_q[0]};
  assign cmd_done = (state_q == ST_CMD) && sclk_rise && (cnt_q == 5'd7);
  assign is_read  = (cmd_q == CMD_READ || cmd_q == CMD_DUAL_IO_RD || cmd_q == CMD_QUAD_IO_RD);
  always_comb
  begin
    sr_view = cur_sr_q[sel_q];
    if (sel_q == 2'd0)
    begin
      sr_view[SR1_BUSY_BIT] = busy_q;
      sr_view[SR1_WEL_BIT]  = wel_q;
    end
    rd_byte = is_read ? mem_rdata : sr_view;
  end

  // link sequencer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      cmd_q       <= 8'h00;
      sh_q        <= 24'h0;
      cnt_q       <= 5'h0;
      lw_q        <= 3'd1;
      din_n_q     <= 2'h0;
      sel_q       <= 2'h0;
      b0_q        <= 8'h00;
      b1_q        <= 8'h00;
      out_sh_q    <= 8'h00;
      bits_left_q <= 4'h0;
      addr_q      <= 24'h0;
      mem_wr_q    <= 1'b0;
      wdata_q     <= 8'h00;
      io_o_q      <= 4'h0;
      io_oe_q     <= 4'h0;
    end
    else
    begin
      mem_wr_q <= 1'b0;
      if (mem_wr_q)
        addr_q[7:0] <= addr_q[7:0] + 8'h1;
      if (cs_s_q[1])
      begin
        state_q <= ST_IDLE;
        io_oe_q <= 4'h0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            state_q     <= ST_CMD;
            cnt_q       <= 5'h0;
            din_n_q     <= 2'h0;
            bits_left_q <= 4'h0;
            lw_q        <= 3'd1;
          end
          ST_CMD:
            if (sclk_rise)
            begin
              sh_q  <= shift_in(sh_q, io_s2_q, 3'd1);
              cnt_q <= cnt_q + 5'h1;
              if (cnt_q == 5'd7)
              begin
                cmd_q   <= in_byte;
                cnt_q   <= 5'h0;
                state_q <= ST_QUIET;
                case (in_byte)
                  CMD_RD_STATUS1, CMD_RD_STATUS2, CMD_RD_STATUS3:
                  begin
                    state_q <= ST_DOUT;
                    sel_q   <= (in_byte == CMD_RD_STATUS1) ? 2'd0 : ((in_byte == CMD_RD_STATUS2) ? 2'd1 : 2'd2);
                  end
                  CMD_READ:
                    if (!busy_q)
                      state_q <= ST_ADDR;
                  CMD_PROGRAM:
                    if (!busy_q && wel_q)
                      state_q <= ST_ADDR;
                  CMD_DUAL_IO_RD:
                    if (!busy_q)
                    begin
                      state_q <= ST_ADDR;
                      lw_q    <= 3'd2;
                    end
                  CMD_QUAD_IO_RD:
                    if (!busy_q && cur_sr_q[1][SR2_QE_BIT])
                    begin
                      state_q <= ST_ADDR;
                      lw_q    <= 3'd4;
                    end
                  CMD_SET_WRAP:
                    if (!busy_q)
                    begin
                      state_q <= ST_DIN;
                      lw_q    <= 3'd4;
                    end
                  CMD_WR_ENABLE, CMD_WR_DISABLE, CMD_VOL_ENABLE, CMD_RESET_EN, CMD_RESET,
                  CMD_WR_STATUS1, CMD_WR_STATUS2, CMD_WR_STATUS3:
                    if (!busy_q)
                      state_q <= ST_DIN;
                  default:
                    state_q <= ST_QUIET;
                endcase
              end
            end
          ST_ADDR, ST_MODE, ST_DUMMY:
            if (sclk_rise)
            begin
              sh_q  <= shift_in(sh_q, io_s2_q, lw_q);
              cnt_q <= cnt_q + 5'h1;
              if (state_q == ST_ADDR && cnt_q == phase_clks(5'(ADDR_BITS), lw_q) - 5'h1)
              begin
                addr_q  <= shift_in(sh_q, io_s2_q, lw_q);
                cnt_q   <= 5'h0;
                state_q <= (cmd_q == CMD_READ) ? ST_DOUT : ((cmd_q == CMD_PROGRAM) ? ST_DIN : ST_MODE);
              end
              // mode bits are taken and dropped: continuous read is not offered
              if (state_q == ST_MODE && cnt_q == phase_clks(5'(MODE_BITS), lw_q) - 5'h1)
              begin
                cnt_q   <= 5'h0;
                state_q <= (cmd_q == CMD_QUAD_IO_RD) ? ST_DUMMY : ST_DOUT;
              end
              if (state_q == ST_DUMMY && cnt_q == 5'(QUAD_DUMMY_CLKS - 1))
                state_q <= ST_DOUT;
            end
          ST_DIN:
            if (sclk_rise)
            begin
              sh_q  <= shift_in(sh_q, io_s2_q, lw_q);
              cnt_q <= cnt_q + 5'h1;
              if (cmd_q == CMD_SET_WRAP && cnt_q == 5'(WRAP_NIBBLE_POS))
                b0_q <= {5'h0, io_s2_q[2:0]};
              else if (lw_q == 3'd1 && cnt_q[2:0] == 3'h7)
              begin
                if (cmd_q == CMD_PROGRAM)
                begin
                  mem_wr_q <= 1'b1;
                  wdata_q  <= in_byte;
                end
                if (din_n_q == 2'd0)
                  b0_q <= in_byte;
                if (din_n_q == 2'd1)
                  b1_q <= in_byte;
                if (din_n_q != 2'd3)
                  din_n_q <= din_n_q + 2'h1;
              end
            end
          ST_DOUT:
            if (sclk_fall)
            begin : drive
              logic [7:0] b;
              b = (bits_left_q == 4'h0) ? rd_byte : out_sh_q;
              // only array reads and program bytes advance the address; status reads leave it alone
              if (bits_left_q == 4'h0 && is_read)
                addr_q <= next_addr(addr_q, cmd_q == CMD_QUAD_IO_RD && !wrap_disable_q, wrap_length_q);
              out_sh_q    <= b << lw_q;
              bits_left_q <= ((bits_left_q == 4'h0) ? 4'h8 : bits_left_q) - {1'b0, lw_q};
              io_o_q  <= (lw_q == 3'd1) ? {2'b00, b[7], 1'b0} : ((lw_q == 3'd2) ? {2'b00, b[7:6]} : b[7:4]);
              io_oe_q <= (lw_q == 3'd1) ? 4'h2 : ((lw_q == 3'd2) ? 4'h3 : 4'hf);
            end
          default:
            io_oe_q <= 4'h0;
        endcase
      end
    end
  end

  // end-of-frame actions, decided on the chip-select rise
  logic din_end, single, wr_ok, vol_go, nv_go, soft_rst;
  assign din_end  = cs_rise && state_q == ST_DIN;
  assign single   = din_end && cnt_q == 5'h0;
  assign wr_ok    = (cmd_q == CMD_WR_STATUS1 && cnt_q[2:0] == 3'h0 && (din_n_q == 2'd1 || din_n_q == 2'd2)) ||
                    ((cmd_q == CMD_WR_STATUS2 || cmd_q == CMD_WR_STATUS3) && din_n_q == 2'd1 && cnt_q == 5'd8);
  assign vol_go   = din_end && wr_ok && vol_arm_q;
  assign nv_go    = din_end && wr_ok && !vol_arm_q && wel_q;
  assign soft_rst = single && cmd_q == CMD_RESET && rst_arm_q;

  // status registers; nothing non-volatile survives rst_n, which stands for power-up
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 3; i++)
      begin
        cur_sr_q[i] <= SR_RESET_VAL;
        nv_sr_q[i]  <= SR_RESET_VAL;
      end
      wel_q          <= 1'b0;
      busy_q         <= 1'b0;
      busy_cnt_q     <= 32'h0;
      vol_arm_q      <= 1'b0;
      rst_arm_q      <= 1'b0;
      wrap_disable_q <= 1'b1;
      wrap_length_q  <= WRAP_LEN_RESET;
    end
    else
    begin
      if (busy_q)
      begin
        busy_cnt_q <= busy_cnt_q - 32'h1;
        if (busy_cnt_q == 32'h1)
        begin
          busy_q <= 1'b0;
          wel_q  <= 1'b0;
        end
      end
      if (cs_rise && state_q != ST_IDLE)
      begin
        vol_arm_q <= single && cmd_q == CMD_VOL_ENABLE;
        rst_arm_q <= single && cmd_q == CMD_RESET_EN;
      end
      if (single && cmd_q == CMD_WR_ENABLE)
        wel_q <= 1'b1;
      if ((single && cmd_q == CMD_WR_DISABLE) || (din_end && cmd_q == CMD_PROGRAM))
        wel_q <= 1'b0;
      if (din_end && cmd_q == CMD_SET_WRAP && cnt_q == 5'(WRAP_CLKS))
      begin
        wrap_disable_q <= b0_q[0];
        wrap_length_q  <= b0_q[2:1];
      end
      if (vol_go || nv_go)
      begin
        if (cmd_q == CMD_WR_STATUS1)
          cur_sr_q[0] <= sr_merge(cur_sr_q[0], b0_q, SR1_WR_MASK, NO_OTP_MASK);
        if (cmd_q == CMD_WR_STATUS2 || (cmd_q == CMD_WR_STATUS1 && din_n_q == 2'd2))
          cur_sr_q[1] <= sr_merge(cur_sr_q[1], (cmd_q == CMD_WR_STATUS2) ? b0_q : b1_q, SR2_WR_MASK, SR2_OTP_MASK);
        if (cmd_q == CMD_WR_STATUS3)
          cur_sr_q[2] <= sr_merge(cur_sr_q[2], b0_q, SR3_WR_MASK, NO_OTP_MASK);
      end
      if (nv_go)
      begin
        if (cmd_q == CMD_WR_STATUS1)
          nv_sr_q[0] <= sr_merge(cur_sr_q[0], b0_q, SR1_WR_MASK, NO_OTP_MASK);
        if (cmd_q == CMD_WR_STATUS2 || (cmd_q == CMD_WR_STATUS1 && din_n_q == 2'd2))
          nv_sr_q[1] <= sr_merge(cur_sr_q[1], (cmd_q == CMD_WR_STATUS2) ? b0_q : b1_q, SR2_WR_MASK, SR2_OTP_MASK);
        if (cmd_q == CMD_WR_STATUS3)
          nv_sr_q[2] <= sr_merge(cur_sr_q[2], b0_q, SR3_WR_MASK, NO_OTP_MASK);
        busy_q     <= 1'b1;
        busy_cnt_q <= 32'(STATUS_WRITE_CLKS);
      end
      if (soft_rst)
      begin
        for (int i = 0; i < 3; i++)
          cur_sr_q[i] <= nv_sr_q[i] | (cur_sr_q[i] & SR2_OTP_MASK & {8{i == 1}});
        wel_q          <= 1'b0;
        wrap_disable_q <= 1'b1;
      end
    end
  end

  assign io_o               = io_o_q;
  assign io_oe              = io_oe_q;
  assign mem_addr           = addr_q;
  assign mem_wr             = mem_wr_q;
  assign mem_wdata          = wdata_q;
  assign busy               = busy_q;
  assign write_enable_latch = wel_q;
  assign quad_lane_enable   = cur_sr_q[1][SR2_QE_BIT];

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_wren_frame;
    single && cmd_q == CMD_WR_ENABLE;
  endsequence
  sequence s_nv_write;
    nv_go;
  endsequence
  a_wel_set:
    assert property (s_wren_frame |=> wel_q) else $error("write enable did not set latch");
  a_wel_clear:
    assert property (single && cmd_q == CMD_WR_DISABLE |=> !wel_q) else $error("write disable left latch set");
  a_vol_arm_wel:
    assert property (single && cmd_q == CMD_VOL_ENABLE |=> wel_q == $past(wel_q) && vol_arm_q)
      else $error("volatile enable changed latch");
  a_nv_busy:
    assert property (s_nv_write |=> busy_q ##0 busy_cnt_q == 32'(STATUS_WRITE_CLKS))
      else $error("non-volatile write did not start busy");
  a_busy_end_wel:
    assert property ($fell(busy_q) |-> !wel_q) else $error("latch set after write cycle");
  a_vol_no_busy:
    assert property (vol_go && !busy_q |-> ##[1:2] !busy_q && !wel_q || $past(wel_q))
      else $error("volatile write raised busy");
  a_lock_sticky:
    assert property ((($past(cur_sr_q[1]) & ~cur_sr_q[1] & SR2_OTP_MASK) == 8'h00))
      else $error("lock bit cleared");
  a_quad_gate:
    assert property (cmd_done && in_byte == CMD_QUAD_IO_RD && !quad_lane_enable |=> state_q == ST_QUIET || cs_s_q[2])
      else $error("quad read accepted without enable");
  a_read_busy:
    assert property (cmd_done && in_byte == CMD_READ && busy_q |=> state_q == ST_QUIET || cs_s_q[2])
      else $error("plain read accepted while busy");
  a_wrap_reset:
    assert property (soft_rst |=> wrap_disable_q) else $error("wrap not disabled after reset");
  a_quiet_oe:
    assert property (state_q == ST_QUIET || state_q == ST_IDLE |=> io_oe_q == 4'h0 || $past(state_q) == ST_DOUT)
      else $error("device drove lanes while quiet");
endmodule // sfs_core
`default_nettype wire
